// File: core/bdcr_config_regs.sv
// Purpose: Serial-programmed configuration slice of a three-phase driver.
// Assumes: One 100 MHz clock; serial, pwm and overcurrent pins pass three-stage synchronisers.
// Notes: Overcurrent supervisor acts on the programmed response.
`timescale 1ns/100ps
module bdcr_config_regs
  import bdcr_pkg::*;
#(
  parameter logic [25:0] RETRY_SHORT_CYC = RETRY_SHORT_CYC_DEF,
  parameter logic [25:0] RETRY_LONG_CYC = RETRY_LONG_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  input wire logic pwm_in,
  input wire logic oc_sense,
  input wire logic clear_fault,
  output logic standby_request,
  output logic overcurrent_threshold,
  output logic overcurrent_fault,
  output logic drive_disable,
  output logic limit_recirculation_path,
  output logic async_rectify_enable,
  output logic sync_rectify_enable,
  output logic [1:0] sense_amp_gain,
  output logic regulator_sequencing_off,
  output logic regulator_current_limit,
  output logic [1:0] regulator_voltage,
  output logic regulator_off,
  output logic position_comparator_hysteresis,
  output logic coast_active,
  output logic brake_active,
  output logic direction,
  output logic [1:0] speed_output_mode,
  output logic regs_locked
);

  logic sclk_lvl;
  logic cs_n_lvl;
  logic sdi_lvl;
  logic pwm_lvl;
  logic oc_lvl;
  logic hdr_valid;
  logic [5:0] frm_addr;
  logic frm_read;
  logic [7:0] frm_data;
  logic frm_done;
  logic [7:0] rd_data;
  logic [7:0] cfg_r [0:NUM_CFG-1];
  logic [2:0] lock_field_r;
  logic wr_ok;
  logic pwm_q_r;
  logic pwm_edge;
  logic cycle_clear;
  logic [7:0] filt_cnt_r;
  logic [7:0] filt_lim;
  logic oc_seen;
  logic [1:0] resp;
  logic [25:0] retry_cnt_r;
  logic [25:0] retry_load;
  logic report_r;
  bdcr_oc_state_type oc_state_r;
  bdcr_oc_state_type oc_state_nxt;

  function automatic logic in_bank(input logic [5:0] addr);
    in_bank = (addr >= OFS_DRV_PROT) && (addr <= OFS_SPEED);
  endfunction

  function automatic logic [2:0] reg_slot(input logic [5:0] addr);
    logic [5:0] d;
    d = addr - OFS_DRV_PROT;
    reg_slot = d[2:0];
  endfunction

  bdcr_pin_sync #(
    .W(5),
    .RST_VAL(5'h08)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in({spi_sclk, spi_cs_n, spi_sdi, pwm_in, oc_sense}),
    .level_out({sclk_lvl, cs_n_lvl, sdi_lvl, pwm_lvl, oc_lvl})
  );

  bdcr_spi_frame u_frame (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .sclk(sclk_lvl),
    .cs_n(cs_n_lvl),
    .sdi(sdi_lvl),
    .rd_data(rd_data),
    .hdr_valid(hdr_valid),
    .frm_addr(frm_addr),
    .frm_read(frm_read),
    .frm_data(frm_data),
    .frm_done(frm_done),
    .sdo(spi_sdo),
    .sdo_oe_n(spi_sdo_oe_n)
  );

  // Read path; unmapped offsets answer zero
  always_comb begin
    rd_data = 8'h00;
    if (in_bank(frm_addr)) begin
      rd_data = cfg_r[reg_slot(frm_addr)];
    end else if (frm_addr == OFS_LOCK) begin
      rd_data = {5'h00, lock_field_r};
    end
  end

  assign wr_ok = frm_done && !frm_read;

  // Whole byte lands only when the frame closes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CFG; i++) begin
        cfg_r[i] <= reg_reset(i);
      end
    end else if (wr_ok && in_bank(frm_addr) && !regs_locked) begin
      cfg_r[reg_slot(frm_addr)] <= frm_data & reg_mask(reg_slot(frm_addr));
    end
  end

  // Lock field stays writable while locked
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_field_r <= RST_LOCK;
      regs_locked <= 1'b0;
    end else if (wr_ok && frm_addr == OFS_LOCK) begin
      lock_field_r <= frm_data[2:0];
      if (frm_data[2:0] == LOCK_CODE) begin
        regs_locked <= 1'b1;
      end else if (frm_data[2:0] == UNLOCK_CODE) begin
        regs_locked <= 1'b0;
      end
    end
  end

  // Plain configuration outputs
  assign standby_request = cfg_r[SLOT_DRV_PROT][B_STANDBY];
  assign overcurrent_threshold = cfg_r[SLOT_DRV_PROT][B_THRESH];
  assign limit_recirculation_path = cfg_r[SLOT_RECT][B_RECIR];
  assign async_rectify_enable = cfg_r[SLOT_RECT][B_ASYNC_RECT];
  assign sync_rectify_enable = cfg_r[SLOT_RECT][B_SYNC_RECT];
  assign sense_amp_gain = cfg_r[SLOT_RECT][F_GAIN_LSB+:2];
  assign regulator_sequencing_off = cfg_r[SLOT_REG][B_SEQ_OFF];
  assign regulator_current_limit = cfg_r[SLOT_REG][B_CLIM];
  assign regulator_voltage = cfg_r[SLOT_REG][F_VSEL_LSB+:2];
  assign regulator_off = cfg_r[SLOT_REG][B_REG_OFF];
  assign position_comparator_hysteresis = cfg_r[SLOT_MOTION][B_HYS];
  assign direction = cfg_r[SLOT_MOTION][B_DIR];
  assign speed_output_mode = cfg_r[SLOT_SPEED][F_FG_LSB+:2];

  // Coast wins over brake so phases never see both at once
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      coast_active <= 1'b0;
      brake_active <= 1'b0;
    end else begin
      coast_active <= cfg_r[SLOT_MOTION][B_COAST] |
                      (cfg_r[SLOT_MOTION][B_BRAKE] &
                       cfg_r[SLOT_MOTION][B_BRK_MODE]);
      brake_active <= cfg_r[SLOT_MOTION][B_BRAKE] &
                      ~cfg_r[SLOT_MOTION][B_BRK_MODE] &
                      ~cfg_r[SLOT_MOTION][B_COAST];
    end
  end

  // PWM input cycle boundary
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm_q_r <= 1'b0;
    end else begin
      pwm_q_r <= pwm_lvl;
    end
  end

  assign pwm_edge = pwm_lvl & ~pwm_q_r;
  assign cycle_clear = pwm_edge & cfg_r[SLOT_DRV_PROT][B_CYC_CLR];
  assign resp = cfg_r[SLOT_DRV_PROT][F_RESP_LSB+:2];

  always_comb begin
    case (cfg_r[SLOT_DRV_PROT][F_FILT_LSB+:2])
      2'h0: filt_lim = FILT0_CYC;
      2'h1: filt_lim = FILT1_CYC;
      2'h2: filt_lim = FILT2_CYC;
      default: filt_lim = FILT3_CYC;
    endcase
  end

  // Filter restarts on any low sample
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_cnt_r <= 8'h00;
    end else if (!oc_lvl) begin
      filt_cnt_r <= 8'h00;
    end else if (filt_cnt_r < filt_lim) begin
      filt_cnt_r <= filt_cnt_r + 8'h01;
    end
  end

  assign oc_seen = oc_lvl && (filt_cnt_r >= filt_lim);
  assign retry_load = cfg_r[SLOT_DRV_PROT][B_RETRY] ?
                      RETRY_LONG_CYC : RETRY_SHORT_CYC;

  // A persisting overcurrent blocks a latched clear and re-enters retry at once after a retry clear
  always_comb begin
    oc_state_nxt = oc_state_r;
    case (oc_state_r)
      OC_IDLE: begin
        if (oc_seen && resp == RESP_LATCH) begin
          oc_state_nxt = OC_LATCHED;
        end else if (oc_seen && resp == RESP_RETRY) begin
          oc_state_nxt = OC_RETRY;
        end
      end
      OC_LATCHED: begin
        if ((clear_fault || cycle_clear) && !oc_seen) begin
          oc_state_nxt = OC_IDLE;
        end
      end
      OC_RETRY: begin
        if (cycle_clear || retry_cnt_r == 26'h0000000) begin
          oc_state_nxt = OC_IDLE;
        end
      end
      default: oc_state_nxt = OC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_state_r <= OC_IDLE;
    end else begin
      oc_state_r <= oc_state_nxt;
    end
  end

  // Wait is counted from entry into retry
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      retry_cnt_r <= 26'h0000000;
    end else if (oc_state_r != OC_RETRY) begin
      retry_cnt_r <= retry_load - 26'h0000001;
    end else if (retry_cnt_r != 26'h0000000) begin
      retry_cnt_r <= retry_cnt_r - 26'h0000001;
    end
  end

  // Report-only flag; a new event beats a same-cycle clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      report_r <= 1'b0;
    end else if (oc_seen && resp == RESP_REPORT) begin
      report_r <= 1'b1;
    end else if (clear_fault || cycle_clear) begin
      report_r <= 1'b0;
    end
  end

  // Code 3 reaches neither output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_disable <= 1'b0;
      overcurrent_fault <= 1'b0;
    end else begin
      drive_disable <= (oc_state_nxt != OC_IDLE);
      overcurrent_fault <= (oc_state_nxt != OC_IDLE) || report_r;
    end
  end

endmodule

// File: core/bdcr_pkg.sv
// Purpose: Shared constants for the motor driver configuration slice.
// Assumes: 100 MHz ref_clk, 16-bit serial frames.
// Notes: Offsets are the printed byte offsets of the serial map.
package bdcr_pkg;

  localparam int CLK_PERIOD_NS = 10;

  // Serial frame layout
  localparam int FRAME_BITS = 16;
  localparam int HDR_BITS = 8;
  localparam int FRM_CNT_W = 5;
  localparam int ADDR_W = 6;

  // Register offsets
  localparam logic [5:0] OFS_LOCK = 6'h03;
  localparam logic [5:0] OFS_DRV_PROT = 6'h06;
  localparam logic [5:0] OFS_RECT = 6'h07;
  localparam logic [5:0] OFS_REG = 6'h08;
  localparam logic [5:0] OFS_MOTION = 6'h09;
  localparam logic [5:0] OFS_SPEED = 6'h0a;
  localparam int NUM_CFG = 5;
  localparam int SLOT_DRV_PROT = 0;
  localparam int SLOT_RECT = 1;
  localparam int SLOT_REG = 2;
  localparam int SLOT_MOTION = 3;
  localparam int SLOT_SPEED = 4;

  // Reset values
  localparam logic [7:0] RST_DRV_PROT = 8'h10;
  localparam logic [7:0] RST_RECT = 8'h00;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_MOTION = 8'h01;
  localparam logic [7:0] RST_SPEED = 8'h41;
  localparam logic [2:0] RST_LOCK = 3'h0;

  // Writable bits; the rest read as zero
  localparam logic [7:0] MASK_DRV_PROT = 8'hff;
  localparam logic [7:0] MASK_RECT = 8'hff;
  localparam logic [7:0] MASK_REG = 8'h3f;
  localparam logic [7:0] MASK_MOTION = 8'h1f;
  localparam logic [7:0] MASK_SPEED = 8'hdf;

  // Field positions
  localparam int B_STANDBY = 7;
  localparam int B_CYC_CLR = 6;
  localparam int F_FILT_LSB = 4;
  localparam int B_RETRY = 3;
  localparam int B_THRESH = 2;
  localparam int F_RESP_LSB = 0;
  localparam int B_RECIR = 6;
  localparam int B_ASYNC_RECT = 3;
  localparam int B_SYNC_RECT = 2;
  localparam int F_GAIN_LSB = 0;
  localparam int B_SEQ_OFF = 4;
  localparam int B_CLIM = 3;
  localparam int F_VSEL_LSB = 1;
  localparam int B_REG_OFF = 0;
  localparam int B_HYS = 4;
  localparam int B_BRK_MODE = 3;
  localparam int B_COAST = 2;
  localparam int B_BRAKE = 1;
  localparam int B_DIR = 0;
  localparam int F_FG_LSB = 6;

  localparam logic [2:0] LOCK_CODE = 3'h6;
  localparam logic [2:0] UNLOCK_CODE = 3'h3;

  // Overcurrent response codes
  localparam logic [1:0] RESP_LATCH = 2'h0;
  localparam logic [1:0] RESP_RETRY = 2'h1;
  localparam logic [1:0] RESP_REPORT = 2'h2;

  // Filter times, rounded up to whole cycles
  localparam int FILT0_NS = 200;
  localparam int FILT1_NS = 600;
  localparam int FILT2_NS = 1250;
  localparam int FILT3_NS = 1600;
  localparam logic [7:0] FILT0_CYC = 8'((FILT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] FILT1_CYC = 8'((FILT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] FILT2_CYC = 8'((FILT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] FILT3_CYC = 8'((FILT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Retry waits
  localparam int RETRY_W = 26;
  localparam int RETRY_SHORT_US = 5000;
  localparam int RETRY_LONG_US = 500000;
  localparam logic [25:0] RETRY_SHORT_CYC_DEF = 26'(RETRY_SHORT_US * 1000 / CLK_PERIOD_NS);
  localparam logic [25:0] RETRY_LONG_CYC_DEF = 26'(RETRY_LONG_US * 1000 / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    OC_IDLE = 2'b00,
    OC_LATCHED = 2'b01,
    OC_RETRY = 2'b10
  } bdcr_oc_state_type;

  function automatic logic [7:0] reg_reset(input int slot);
    case (slot)
      SLOT_DRV_PROT: reg_reset = RST_DRV_PROT;
      SLOT_RECT: reg_reset = RST_RECT;
      SLOT_REG: reg_reset = RST_REG;
      SLOT_MOTION: reg_reset = RST_MOTION;
      default: reg_reset = RST_SPEED;
    endcase
  endfunction

  function automatic logic [7:0] reg_mask(input logic [2:0] slot);
    case (slot)
      3'h0: reg_mask = MASK_DRV_PROT;
      3'h1: reg_mask = MASK_RECT;
      3'h2: reg_mask = MASK_REG;
      3'h3: reg_mask = MASK_MOTION;
      3'h4: reg_mask = MASK_SPEED;
      default: reg_mask = 8'h00;
    endcase
  endfunction

endpackage

// File: core/bdcr_pin_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Inputs asynchronous to ref_clk.
// Notes: Output moves only when stages two and three agree.
`timescale 1ns/100ps
module bdcr_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_nxt;

  // Stage one feeds stage two only
  always_comb begin
    level_nxt = (s2_r & ~(s2_r ^ s3_r)) | (level_out & (s2_r ^ s3_r));
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_out <= RST_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_out <= level_nxt;
    end
  end

endmodule

// File: core/bdcr_spi_frame.sv
// Purpose: 16-bit serial frame engine for register access.
// Assumes: Mode 0 framing, inputs already synchronised.
// Notes: Only frames of exactly 16 clocks are reported.
`timescale 1ns/100ps
module bdcr_spi_frame
  import bdcr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [7:0] rd_data,
  output logic hdr_valid,
  output logic [5:0] frm_addr,
  output logic frm_read,
  output logic [7:0] frm_data,
  output logic frm_done,
  output logic sdo,
  output logic sdo_oe_n
);

  logic sclk_q_r;
  logic cs_q_r;
  logic [FRM_CNT_W-1:0] bit_cnt_r;
  logic [FRAME_BITS-1:0] rx_r;
  logic [7:0] tx_r;
  logic rise;
  logic fall;

  assign rise = sclk & ~sclk_q_r & ~cs_n;
  assign fall = ~sclk & sclk_q_r & ~cs_n;
  assign frm_data = rx_r[7:0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      bit_cnt_r <= '0;
      rx_r <= '0;
      frm_addr <= '0;
      frm_read <= 1'b0;
      hdr_valid <= 1'b0;
      frm_done <= 1'b0;
    end else begin
      sclk_q_r <= sclk;
      cs_q_r <= cs_n;
      hdr_valid <= rise && (bit_cnt_r == FRM_CNT_W'(HDR_BITS - 1));
      frm_done <= cs_n && !cs_q_r &&
                  (bit_cnt_r == FRM_CNT_W'(FRAME_BITS));
      if (!cs_n && cs_q_r) begin
        bit_cnt_r <= '0;
      end else if (rise) begin
        rx_r <= {rx_r[FRAME_BITS-2:0], sdi};
        if (bit_cnt_r != '1) begin
          bit_cnt_r <= bit_cnt_r + 1'b1;
        end
        if (bit_cnt_r == FRM_CNT_W'(HDR_BITS - 1)) begin
          frm_read <= rx_r[6];
          frm_addr <= rx_r[5:0];
        end
      end
    end
  end

  // First byte out is zero; register data follows
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= '0;
      sdo <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      sdo_oe_n <= cs_n;
      if (hdr_valid) begin
        tx_r <= rd_data;
      end else if (fall && bit_cnt_r >= FRM_CNT_W'(HDR_BITS)) begin
        sdo <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end else if (fall || (!cs_n && cs_q_r)) begin
        sdo <= 1'b0;
      end
    end
  end

endmodule

// File: sim/bdcr_config_regs_assertions.sv
// Purpose: Port-level checks for the configuration slice.
// Assumes: One ref_clk domain, rst_n async active low.
// Notes: Bound to the design top at the foot of this file.
`timescale 1ns/100ps
module bdcr_config_regs_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_cs_n,
  input wire logic pwm_in,
  input wire logic oc_sense,
  input wire logic clear_fault,
  input wire logic spi_sdo_oe_n,
  input wire logic standby_request,
  input wire logic overcurrent_fault,
  input wire logic drive_disable,
  input wire logic [1:0] sense_amp_gain,
  input wire logic coast_active,
  input wire logic brake_active,
  input wire logic direction,
  input wire logic [1:0] speed_output_mode,
  input wire logic regs_locked
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence cfg_change;
    $changed(direction) || $changed(sense_amp_gain);
  endsequence

  // Pwm held low long enough that no cycle clear is in the pipeline
  sequence oc_quiet_rise;
    (!pwm_in) [*6] ##0 ($rose(drive_disable) && !clear_fault);
  endsequence

  a_oe_idle: assert property (spi_cs_n [*8] |-> spi_sdo_oe_n)
    else $error("sdo enabled outside a frame");
  a_oe_frame: assert property (!spi_cs_n [*8] |-> !spi_sdo_oe_n)
    else $error("sdo not enabled inside a frame");
  a_write_timing: assert property (cfg_change |->
    $past(spi_cs_n, 1) && $past(spi_cs_n, 3))
    else $error("config changed before frame end");
  a_lock_hold: assert property (regs_locked |=> $stable(direction) &&
    $stable(standby_request) && $stable(speed_output_mode))
    else $error("config changed while locked");
  a_brake_excl: assert property (!(coast_active && brake_active))
    else $error("coast and brake both active");
  a_disable_fault: assert property (drive_disable |-> overcurrent_fault)
    else $error("drive disabled without fault report");
  a_no_spurious: assert property (!oc_sense [*8] |->
    !$rose(overcurrent_fault))
    else $error("fault rose without overcurrent");
  a_disable_hold: assert property (oc_quiet_rise ##1
    (!clear_fault && !pwm_in) [*4] |-> drive_disable)
    else $error("drive disable dropped early");
endmodule

bind bdcr_config_regs bdcr_config_regs_assertions bdcr_config_regs_assertions_i (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .spi_cs_n(spi_cs_n),
  .pwm_in(pwm_in),
  .oc_sense(oc_sense),
  .clear_fault(clear_fault),
  .spi_sdo_oe_n(spi_sdo_oe_n),
  .standby_request(standby_request),
  .overcurrent_fault(overcurrent_fault),
  .drive_disable(drive_disable),
  .sense_amp_gain(sense_amp_gain),
  .coast_active(coast_active),
  .brake_active(brake_active),
  .direction(direction),
  .speed_output_mode(speed_output_mode),
  .regs_locked(regs_locked)
);

// File: sim/bdcr_spi_host.sv
// Purpose: Serial host that configures the driver slice.
// Assumes: Mode 0, MSB first, half period given in ref_clk cycles.
// Notes: Short frames are sent on purpose to test refusal.
`timescale 1ns/100ps
module bdcr_spi_host (
  input wire logic ref_clk,
  input wire logic sdo,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  task automatic xfer(input logic [15:0] frm, input int half,
      input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk);
    #1 cs_n = 1'b0;
    for (int i = 15; i > 15 - nbits; i--) begin
      sdi = frm[i];
      repeat (half) @(posedge ref_clk);
      #1 sclk = 1'b1;
      if (i < 8) begin
        rd = {rd[6:0], sdo};
      end
      repeat (half) @(posedge ref_clk);
      #1 sclk = 1'b0;
    end
    repeat (half) @(posedge ref_clk);
    #1 cs_n = 1'b1;
    // Released line must not keep looking like data
    sdi = ~sdi;
    // Gap covers the write landing and the idle time between frames
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

// File: sim/test_bdcr_config_regs.sv
// Purpose: Self-checking bench for the configuration slice.
// Assumes: Retry counts shortened to 20 and 50 cycles.
// Notes: Random register data from a fixed seed plus corner values.
`timescale 1ns/100ps
module test_bdcr_config_regs
  import bdcr_pkg::*;
;
  logic ref_clk, rst_n, pwm_in, oc_sense, clear_fault;
  logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
  logic standby_request, overcurrent_threshold, overcurrent_fault;
  logic drive_disable, limit_recirculation_path, async_rectify_enable;
  logic sync_rectify_enable, regulator_sequencing_off, regs_locked;
  logic regulator_current_limit, regulator_off, direction;
  logic position_comparator_hysteresis, coast_active, brake_active;
  logic [1:0] sense_amp_gain, regulator_voltage, speed_output_mode;
  int fail_count;
  int checked;
  int cycles;
  int seed_val;

  bdcr_config_regs #(.RETRY_SHORT_CYC(26'h14), .RETRY_LONG_CYC(26'h32))
      bdcr_config_regs_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n), .pwm_in(pwm_in), .oc_sense(oc_sense),
    .clear_fault(clear_fault), .standby_request(standby_request),
    .overcurrent_threshold(overcurrent_threshold),
    .overcurrent_fault(overcurrent_fault), .drive_disable(drive_disable),
    .limit_recirculation_path(limit_recirculation_path),
    .async_rectify_enable(async_rectify_enable),
    .sync_rectify_enable(sync_rectify_enable),
    .sense_amp_gain(sense_amp_gain),
    .regulator_sequencing_off(regulator_sequencing_off),
    .regulator_current_limit(regulator_current_limit),
    .regulator_voltage(regulator_voltage), .regulator_off(regulator_off),
    .position_comparator_hysteresis(position_comparator_hysteresis),
    .coast_active(coast_active), .brake_active(brake_active),
    .direction(direction), .speed_output_mode(speed_output_mode),
    .regs_locked(regs_locked)
  );

  bdcr_spi_host bdcr_spi_host_i (.ref_clk(ref_clk), .sdo(spi_sdo),
    .sclk(spi_sclk), .cs_n(spi_cs_n), .sdi(spi_sdi));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp,
      input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input int h);
    logic [7:0] r;
    bdcr_spi_host_i.xfer({1'b0, a, 1'b0, d}, h, 16, r);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] r;
    bdcr_spi_host_i.xfer({1'b1, a, 1'b0, 8'h00}, 8, 16, r);
    chk("read data", exp, r);
  endtask

  task automatic cyc(input int n, input logic oc, input logic clr);
    @(posedge ref_clk);
    #1 oc_sense = oc;
    clear_fault = clr;
    repeat (n) @(posedge ref_clk);
    #1 oc_sense = 1'b0;
    clear_fault = 1'b0;
  endtask

  function automatic logic [7:0] exp_out(input int s, input logic [7:0] v);
    case (s)
      0: exp_out = v & 8'h84;
      1: exp_out = v & 8'h4f;
      2: exp_out = v & 8'h1f;
      default: exp_out = {4'h0, v[4], v[2] | (v[1] & v[3]),
        v[1] & ~v[3] & ~v[2], v[0]};
    endcase
  endfunction

  function automatic logic [7:0] obs(input int s);
    case (s)
      0: obs = {standby_request, 4'h0, overcurrent_threshold, 2'h0};
      1: obs = {1'b0, limit_recirculation_path, 2'h0, async_rectify_enable,
        sync_rectify_enable, sense_amp_gain};
      2: obs = {3'h0, regulator_sequencing_off, regulator_current_limit,
        regulator_voltage, regulator_off};
      default: obs = {4'h0, position_comparator_hysteresis, coast_active,
        brake_active, direction};
    endcase
  endfunction

  function automatic logic [7:0] flt();
    return {6'h0, overcurrent_fault, drive_disable};
  endfunction

  initial begin
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] rst_tab [5];
    logic [7:0] msk [4];
    logic [3:0] oc_tab [4];
    rst_tab = '{RST_DRV_PROT, RST_RECT, RST_REG, RST_MOTION, RST_SPEED};
    msk = '{MASK_DRV_PROT, MASK_RECT, MASK_REG, MASK_MOTION};
    oc_tab = '{4'hf, 4'hc, 4'ha, 4'h0};
    fail_count = 0;
    checked = 0;
    cycles = 0;
    seed_val = $urandom(32'ha5552885);
    rst_n = 1'b0;
    pwm_in = 1'b0;
    oc_sense = 1'b0;
    clear_fault = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (5) @(posedge ref_clk);
    for (int i = 0; i < 5; i++) rd_chk(6'h06 + 6'(i), rst_tab[i]);
    rd_chk(6'h03, 8'h00);
    rd_chk(6'h20, 8'h00);
    for (int s = 0; s < 4; s++) chk("outputs", exp_out(s, rst_tab[s]), obs(s));
    chk("speed mode", 8'h01, {6'h0, speed_output_mode});
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 6; k++) begin
        v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
        wr(6'h06 + 6'(s), v, (k % 2 == 1) ? 20 : 8);
        chk("outputs", exp_out(s, v), obs(s));
        rd_chk(6'h06 + 6'(s), v & msk[s]);
      end
    end
    wr(6'h0a, 8'hff, 8);
    rd_chk(6'h0a, MASK_SPEED);
    $display("test read write done");
    wr(6'h09, 8'h00, 8);
    bdcr_spi_host_i.xfer({1'b0, 6'h09, 1'b0, 8'h01}, 8, 15, r);
    chk("direction", 8'h00, {7'h0, direction});
    wr(6'h03, 8'h06, 8);
    chk("locked", 8'h01, {7'h0, regs_locked});
    wr(6'h09, 8'h11, 8);
    chk("outputs", exp_out(3, 8'h00), obs(3));
    rd_chk(6'h03, 8'h06);
    wr(6'h03, 8'h03, 8);
    chk("locked", 8'h00, {7'h0, regs_locked});
    wr(6'h09, 8'h11, 8);
    chk("outputs", exp_out(3, 8'h11), obs(3));
    $display("test lock done");
    for (int c = 0; c < 4; c++) begin
      wr(6'h06, 8'h08 | 8'(c), 8);
      cyc(30, 1'b1, 1'b0);
      repeat (20) @(posedge ref_clk);
      chk("fault", {6'h0, oc_tab[c][3:2]}, flt());
      repeat (80) @(posedge ref_clk);
      chk("fault", {6'h0, oc_tab[c][1:0]}, flt());
      cyc(1, 1'b0, 1'b1);
      repeat (3) @(posedge ref_clk);
      chk("fault", 8'h00, flt());
    end
    // Short wait must end well before the long one would
    wr(6'h06, 8'h01, 8);
    cyc(30, 1'b1, 1'b0);
    chk("fault", 8'h03, flt());
    repeat (20) @(posedge ref_clk);
    chk("fault", 8'h00, flt());
    wr(6'h06, 8'h30, 8);
    cyc(100, 1'b1, 1'b0);
    repeat (20) @(posedge ref_clk);
    chk("fault", 8'h00, flt());
    cyc(200, 1'b1, 1'b0);
    repeat (20) @(posedge ref_clk);
    chk("fault", 8'h03, flt());
    wr(6'h06, 8'h40, 8);
    chk("fault", 8'h03, flt());
    @(posedge ref_clk);
    #1 pwm_in = 1'b1;
    repeat (10) @(posedge ref_clk);
    chk("fault", 8'h00, flt());
    #1 pwm_in = 1'b0;
    $display("test overcurrent done");
    stop_test();
  end
endmodule
